// ===== verilog/pci_pkg.sv
// Constants for the port-one control and interrupt source registers
package pci_pkg;
   localparam int          DATA_W          = 32;
   localparam int          HALF_W          = 16;
   localparam int          NUM_FLAGS       = 7;

   // Register byte offsets
   localparam logic [15:0] OFF_IRQ_SRC     = 16'h0310;
   localparam logic [15:0] OFF_PORT1_CTRL  = 16'h0374;

   // Interrupt source field positions
   localparam int          POS_ISO_DONE    = 9;
   localparam int          POS_ASYNC_DONE  = 8;
   localparam int          POS_PERIOD_DONE = 7;
   localparam int          POS_CLK_STABLE  = 6;
   localparam int          POS_SUSPEND     = 5;
   localparam int          POS_DMA_END     = 3;
   localparam int          POS_FRAME_START = 1;
   localparam logic [NUM_FLAGS-1:0] IRQ_SRC_RESET = 7'h00;

   // Flag bank index order
   localparam int          IDX_ISO         = 6;
   localparam int          IDX_ASYNC       = 5;
   localparam int          IDX_PERIOD      = 4;
   localparam int          IDX_CLK         = 3;
   localparam int          IDX_SUSP        = 2;
   localparam int          IDX_DMA         = 1;
   localparam int          IDX_SOF         = 0;

   // Port one control field positions
   localparam int          POS_INIT_CLEAR  = 23;
   localparam int          POS_INIT_FLAG   = 7;
   localparam int          POS_POWER_HI    = 4;
   localparam int          POS_POWER_LO    = 3;
   // Stored half: union of the two half reset patterns
   localparam logic [HALF_W-1:0] PORT1_RESET = 16'h0096;

   typedef enum logic [1:0] {
      CK_RUN   = 2'b01,
      CK_GATED = 2'b10
   } pci_clk_state_t;
endpackage : pci_pkg

// ===== verilog/pci_flag_if.sv
// Interface between the register top and its sticky flag bank
`timescale 1ns/1ps
`default_nettype none
interface pci_flag_if #(
   parameter int N = 7
);
   logic [N-1:0] setEvt;
   logic [N-1:0] clrReq;
   logic [N-1:0] flags;

   modport bank (input setEvt, input clrReq, output flags);
   modport user (output setEvt, output clrReq, input flags);
endinterface : pci_flag_if
`default_nettype wire

// ===== verilog/pci_flag_bank.sv
// Sticky event flags with write-one-to-clear; set beats clear
`timescale 1ns/1ps
`default_nettype none
module pci_flag_bank #(
   parameter int                N         = 7,
   parameter logic [N-1:0]      RESET_VAL = '0
) (
   input  wire logic            clk,   // System clock
   input  wire logic            rst_n, // Synchronous reset, active low
   pci_flag_if.bank             fb     // Events, clears and flag state
);
   logic [N-1:0] flags_q;
   logic [N-1:0] flags_d;

   always_comb begin
      flags_d = (flags_q & ~fb.clrReq) | fb.setEvt;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_q <= RESET_VAL;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign fb.flags = flags_q;
endmodule : pci_flag_bank
`default_nettype wire

// ===== verilog/pci_regs.sv
// Port-one control register and interrupt source register bank
`timescale 1ns/1ps
`default_nettype none
module pci_regs #(
   parameter int ADDR_W = 16
) (
   input  wire logic               clk,            // System clock, 25 MHz
   input  wire logic               rst_n,          // Sync reset, active low
   // Register port
   input  wire logic [ADDR_W-1:0]  regAddr,        // Byte address
   input  wire logic               regWr,          // Write strobe
   input  wire logic               regRd,          // Read strobe
   input  wire logic [31:0]        regWrData,      // Write data
   output logic      [31:0]        regRdData,      // Read data, registered
   output logic                    regRdValid,     // Read data valid pulse
   // Event sources
   input  wire logic               isoDoneEvt,     // Iso list done
   input  wire logic               asyncDoneEvt,   // Async list done
   input  wire logic               periodDoneEvt,  // Periodic list done
   input  wire logic               suspendEvt,     // Suspend entered
   input  wire logic               dmaEndEvt,      // DMA transfer end
   input  wire logic               frameStartEvt,  // Frame start
   input  wire logic               clocksStopped,  // Clocks gated in suspend
   input  wire logic               clocksStable,   // All clocks running
   // Interrupt gating
   input  wire logic               globalIntEn,    // Global interrupt enable
   input  wire logic [31:0]        intEnableMask,  // Per-source enables
   output logic                    irqLine,        // Interrupt request
   // Port one controls
   output logic [1:0]              firstPortPowerField, // Port power
   output logic                    firstPortInitFlag    // Port init pending
);
   localparam int HW = pci_pkg::HALF_W;
   localparam int NF = pci_pkg::NUM_FLAGS;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   logic hitIrq;
   logic hitPort;
   logic wrIrq;
   logic wrPort;

   always_comb begin
      hitIrq  = (regAddr == ADDR_W'(pci_pkg::OFF_IRQ_SRC));
      hitPort = (regAddr == ADDR_W'(pci_pkg::OFF_PORT1_CTRL));
      wrIrq   = regWr && hitIrq;
      wrPort  = regWr && hitPort;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock-restart tracker

   pci_pkg::pci_clk_state_t ckState_q;
   pci_pkg::pci_clk_state_t ckState_d;
   logic                    clkReadyEvt;

   always_comb begin
      ckState_d   = ckState_q;
      clkReadyEvt = 1'b0;
      case (ckState_q)
         pci_pkg::CK_RUN: begin
            if (clocksStopped) begin
               ckState_d = pci_pkg::CK_GATED;
            end
         end
         pci_pkg::CK_GATED: begin
            // Flag only once every clock is back and stable
            if (!clocksStopped && clocksStable) begin
               ckState_d   = pci_pkg::CK_RUN;
               clkReadyEvt = 1'b1;
            end
         end
         default: begin
            ckState_d = pci_pkg::CK_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ckState_q <= pci_pkg::CK_RUN;
      end else begin
         ckState_q <= ckState_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt source flags

   pci_flag_if #(.N(NF)) flagBus ();

   // Events feed the bank directly; global enable is not consulted here
   always_comb begin
      flagBus.setEvt                    = '0;
      flagBus.setEvt[pci_pkg::IDX_ISO]    = isoDoneEvt;
      flagBus.setEvt[pci_pkg::IDX_ASYNC]  = asyncDoneEvt;
      flagBus.setEvt[pci_pkg::IDX_PERIOD] = periodDoneEvt;
      flagBus.setEvt[pci_pkg::IDX_CLK]    = clkReadyEvt;
      flagBus.setEvt[pci_pkg::IDX_SUSP]   = suspendEvt;
      flagBus.setEvt[pci_pkg::IDX_DMA]    = dmaEndEvt;
      flagBus.setEvt[pci_pkg::IDX_SOF]    = frameStartEvt;
   end

   // Only ones clear; zeros leave the flag alone
   always_comb begin
      flagBus.clrReq = '0;
      if (wrIrq) begin
         flagBus.clrReq[pci_pkg::IDX_ISO] =
            regWrData[pci_pkg::POS_ISO_DONE];
         flagBus.clrReq[pci_pkg::IDX_ASYNC] =
            regWrData[pci_pkg::POS_ASYNC_DONE];
         flagBus.clrReq[pci_pkg::IDX_PERIOD] =
            regWrData[pci_pkg::POS_PERIOD_DONE];
         flagBus.clrReq[pci_pkg::IDX_CLK] =
            regWrData[pci_pkg::POS_CLK_STABLE];
         flagBus.clrReq[pci_pkg::IDX_SUSP] =
            regWrData[pci_pkg::POS_SUSPEND];
         flagBus.clrReq[pci_pkg::IDX_DMA] =
            regWrData[pci_pkg::POS_DMA_END];
         flagBus.clrReq[pci_pkg::IDX_SOF] =
            regWrData[pci_pkg::POS_FRAME_START];
      end
   end

   pci_flag_bank #(
      .N         (NF),
      .RESET_VAL (pci_pkg::IRQ_SRC_RESET)
   ) u_flags (
      .clk   (clk),
      .rst_n (rst_n),
      .fb    (flagBus.bank)
   );

   logic [31:0] irqWord;

   always_comb begin
      irqWord = '0;
      irqWord[pci_pkg::POS_ISO_DONE]    = flagBus.flags[pci_pkg::IDX_ISO];
      irqWord[pci_pkg::POS_ASYNC_DONE]  = flagBus.flags[pci_pkg::IDX_ASYNC];
      irqWord[pci_pkg::POS_PERIOD_DONE] = flagBus.flags[pci_pkg::IDX_PERIOD];
      irqWord[pci_pkg::POS_CLK_STABLE]  = flagBus.flags[pci_pkg::IDX_CLK];
      irqWord[pci_pkg::POS_SUSPEND]     = flagBus.flags[pci_pkg::IDX_SUSP];
      irqWord[pci_pkg::POS_DMA_END]     = flagBus.flags[pci_pkg::IDX_DMA];
      irqWord[pci_pkg::POS_FRAME_START] = flagBus.flags[pci_pkg::IDX_SOF];
   end

   ////////////////////////////////////////////////////////////////////////
   // Port one control: one stored half, mirrored on read

   logic [HW-1:0] port_q;
   logic [HW-1:0] port_d;

   always_comb begin
      port_d = port_q;
      if (wrPort) begin
         // Other bits are plain storage; init flag is sticky until cleared
         port_d = regWrData[HW-1:0];
         port_d[pci_pkg::POS_INIT_FLAG] = port_q[pci_pkg::POS_INIT_FLAG]
                                        | regWrData[pci_pkg::POS_INIT_FLAG];
         if (regWrData[pci_pkg::POS_INIT_CLEAR]) begin
            // Clears both halves' view, so bit 23 reads back zero too
            port_d[pci_pkg::POS_INIT_FLAG] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         port_q <= pci_pkg::PORT1_RESET;
      end else begin
         port_q <= port_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path and registered outputs

   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic        rdValid_q;
   logic        rdValid_d;
   logic        irq_q;
   logic        irq_d;
   logic [1:0]  power_q;
   logic [1:0]  power_d;
   logic        init_q;
   logic        init_d;

   always_comb begin
      rdValid_d = regRd;
      rdData_d  = rdData_q;
      if (regRd) begin
         if (hitIrq) begin
            rdData_d = irqWord;
         end else if (hitPort) begin
            rdData_d = {port_q, port_q};
         end else begin
            rdData_d = '0;
         end
      end
      // Line raised only for enabled sources
      irq_d   = globalIntEn && |(irqWord & intEnableMask);
      power_d = port_d[pci_pkg::POS_POWER_HI:pci_pkg::POS_POWER_LO];
      init_d  = port_d[pci_pkg::POS_INIT_FLAG];
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_q  <= '0;
         rdValid_q <= 1'b0;
         irq_q     <= 1'b0;
         power_q   <= pci_pkg::PORT1_RESET[pci_pkg::POS_POWER_HI:
                                           pci_pkg::POS_POWER_LO];
         init_q    <= pci_pkg::PORT1_RESET[pci_pkg::POS_INIT_FLAG];
      end else begin
         rdData_q  <= rdData_d;
         rdValid_q <= rdValid_d;
         irq_q     <= irq_d;
         power_q   <= power_d;
         init_q    <= init_d;
      end
   end

   assign regRdData           = rdData_q;
   assign regRdValid          = rdValid_q;
   assign irqLine             = irq_q;
   assign firstPortPowerField = power_q;
   assign firstPortInitFlag   = init_q;
endmodule : pci_regs
`default_nettype wire

// ===== tb/pci_regs_assertions.sv
// Concurrent checks on readback, event flags and port-one outputs
`timescale 1ns/1ps
`default_nettype none
module pci_regs_assertions #(
   parameter int ADDR_W = 16
) (
   input wire logic              clk,                 // Clock
   input wire logic              rst_n,               // Reset
   input wire logic [ADDR_W-1:0] regAddr,             // Address
   input wire logic              regWr,               // Write
   input wire logic              regRd,               // Read
   input wire logic [31:0]       regWrData,           // Write data
   input wire logic [31:0]       regRdData,           // Read data
   input wire logic              frameStartEvt,       // Frame event
   input wire logic              clocksStopped,       // Gated
   input wire logic              clocksStable,        // Running
   input wire logic [1:0]        firstPortPowerField, // Power
   input wire logic              firstPortInitFlag    // Init
);
   logic rdI, rdP, wrI, wrP;
   assign rdI = regRd && regAddr == pci_pkg::OFF_IRQ_SRC;
   assign rdP = regRd && regAddr == pci_pkg::OFF_PORT1_CTRL;
   assign wrI = regWr && regAddr == pci_pkg::OFF_IRQ_SRC;
   assign wrP = regWr && regAddr == pci_pkg::OFF_PORT1_CTRL;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_sof; frameStartEvt ##1 rdI; endsequence
   sequence s_wake;
      clocksStopped ##1 (!clocksStopped && clocksStable) ##1 rdI; endsequence
   // No frame event may re-arm the flag before the read samples it
   sequence s_clr;
      (wrI && regWrData[1] && !frameStartEvt) ##1 !frameStartEvt ##1 rdI;
   endsequence
   // Event gone before the zero write, so only the write could clear it
   sequence s_keep;
      frameStartEvt ##2 (wrI && !regWrData[1] && !frameStartEvt) ##1 !wrI
         ##1 rdI;
   endsequence
   property p_half; $past(rdP) |-> regRdData[31:16] == regRdData[15:0];
   endproperty
   a_half: assert property (p_half) else $error("halves differ");
   property p_init; wrP && regWrData[23] |-> ##2 !firstPortInitFlag;
   endproperty
   a_init: assert property (p_init) else $error("init not cleared");
   property p_clr; s_clr |=> !regRdData[1];
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_sof; s_sof |=> regRdData[1];
   endproperty
   a_sof: assert property (p_sof) else $error("flag not set");
   property p_rsv; $past(rdI) |-> (regRdData & 32'hFFFF_FC15) == 32'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_pwr; wrP |-> ##2 firstPortPowerField == $past(regWrData[4:3], 2);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power field wrong");
   property p_wake; s_wake |=> regRdData[6];
   endproperty
   a_wake: assert property (p_wake) else $error("clock flag missing");
   property p_keep; s_keep |=> regRdData[1];
   endproperty
   a_keep: assert property (p_keep) else $error("flag lost");
endmodule : pci_regs_assertions
bind pci_regs pci_regs_assertions #(.ADDR_W(ADDR_W)) i_chk (.clk(clk),
   .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
   .regWrData(regWrData), .regRdData(regRdData),
   .frameStartEvt(frameStartEvt), .clocksStopped(clocksStopped),
   .clocksStable(clocksStable), .firstPortPowerField(firstPortPowerField),
   .firstPortInitFlag(firstPortInitFlag));
`default_nettype wire

// ===== tb/pci_host.sv
// Processor model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pci_host (
   input  wire logic        clk,       // Clock
   output logic      [15:0] regAddr,   // Address
   output logic             regWr,     // Write
   output logic             regRd,     // Read
   output logic      [31:0] regWrData, // Write data
   input  wire logic [31:0] regRdData, // Read data
   input  wire logic        regRdValid // Read valid
);
   initial begin
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 16'hFFFF;
      regWrData = 32'h0;
   end
   // Idle bus shows inverted values so stale data is never trusted
   task automatic wr(logic [15:0] a, logic [31:0] d);
      @(negedge clk);
      {regAddr, regWrData, regWr} = {a, d, 1'b1};
      @(negedge clk);
      {regAddr, regWrData, regWr} = {~a, ~d, 1'b0};
   endtask : wr
   task automatic rd(logic [15:0] a, output logic [31:0] d);
      @(negedge clk);
      {regAddr, regRd} = {a, 1'b1};
      @(negedge clk);
      {regAddr, regRd} = {~a, 1'b0};
      d = regRdValid ? regRdData : 32'hX;
   endtask : rd
   task automatic init();
      wr(pci_pkg::OFF_IRQ_SRC, 32'h0000_03EA);
      wr(pci_pkg::OFF_PORT1_CTRL, 32'h0080_0018);
   endtask : init
endmodule : pci_host
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for port-one control and interrupt source registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [15:0] IRQ = pci_pkg::OFF_IRQ_SRC;
   localparam logic [15:0] PRT = pci_pkg::OFF_PORT1_CTRL;
   logic        clk, regWr, regRd, regRdValid, irqLine, initFlag;
   logic        rst_n = 1'b0;
   logic        stopped = 1'b0;
   logic        stable = 1'b1;
   logic        gie = 1'b0;
   logic [31:0] mask = 32'h0000_03EA;
   logic [1:0]  power;
   logic [5:0]  ev = 6'h00;
   logic [15:0] regAddr;
   logic [31:0] regWrData, regRdData, rdv;
   int          miscompares = 0;
   int          cmpCount = 0;
   pci_regs i_pci_regs (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
      .regRdData(regRdData), .regRdValid(regRdValid), .isoDoneEvt(ev[5]),
      .asyncDoneEvt(ev[4]), .periodDoneEvt(ev[3]), .suspendEvt(ev[2]),
      .dmaEndEvt(ev[1]), .frameStartEvt(ev[0]), .clocksStopped(stopped),
      .clocksStable(stable), .globalIntEn(gie),
      .intEnableMask(mask), .irqLine(irqLine),
      .firstPortPowerField(power), .firstPortInitFlag(initFlag));
   pci_host i_pci_host (.clk(clk), .regAddr(regAddr), .regWr(regWr),
      .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmpCount++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rdc(string n, logic [15:0] a, logic [31:0] e);
      i_pci_host.rd(a, rdv);
      chk(n, rdv, e);
   endtask : rdc
   task automatic finalReport();
      if (miscompares == 0 && cmpCount > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finalReport
   task automatic tPort();
      chk("out rst", {28'h0, irqLine, power, initFlag}, 32'h5);
      rdc("port rst", PRT, 32'h0096_0096);
      rdc("flag rst", IRQ, 32'h0000_0000);
      rdc("unmapped", 16'h0300, 32'h0000_0000);
      i_pci_host.init();
      @(negedge clk);
      chk("power", {29'h0, power, initFlag}, 32'h6);
      rdc("port init", PRT, 32'h0018_0018);
      i_pci_host.wr(PRT, 32'h0000_0098);
      rdc("init set", PRT, 32'h0098_0098);
      i_pci_host.wr(PRT, 32'h0080_0098);
      rdc("init both", PRT, 32'h0018_0018);
   endtask : tPort
   task automatic tFlags();
      for (int i = 5; i >= 0; i--) begin
         @(negedge clk);
         ev = 6'h01 << i;
      end
      rdc("events", IRQ, 32'h0000_03AA);
      ev = 6'h00;
      {stopped, stable} = 2'b10;
      @(negedge clk);
      {stopped, stable} = 2'b01;
      rdc("clock up", IRQ, 32'h0000_03EA);
      chk("irq off", {31'h0, irqLine}, 32'h0);
      {gie, mask} = {1'b1, 32'h0000_0000};
      @(negedge clk);
      chk("irq masked", {31'h0, irqLine}, 32'h0);
      mask = 32'h0000_03EA;
      @(negedge clk);
      chk("irq on", {31'h0, irqLine}, 32'h1);
      i_pci_host.wr(IRQ, 32'h0000_0002);
      rdc("clear one", IRQ, 32'h0000_03E8);
      ev = 6'h01;
      @(negedge clk);
      ev = 6'h00;
      i_pci_host.wr(IRQ, 32'h0000_0000);
      rdc("write 0", IRQ, 32'h0000_03EA);
      i_pci_host.wr(IRQ, 32'h0000_03EA);
      rdc("clear all", IRQ, 32'h0000_0000);
      chk("irq clear", {31'h0, irqLine}, 32'h0);
   endtask : tFlags
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      tPort();
      tFlags();
      finalReport();
   end
   // Run takes about 60 cycles; wide margin
   initial begin
      #100000;
      miscompares++;
      finalReport();
   end
endmodule : testbench
`default_nettype wire
